// [rtl/cbt_core.sv]
// Bit-timing generator and operating-mode control of the bus controller
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module cbt_core (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire cbt_pkg::cbt_bus_req_s bus_req,
  output logic [7:0] rd_data,
  // Processor mode
  input wire logic [1:0] cpu_mode,
  // Bit stream side
  input wire logic tx_active,
  input wire logic tx_bit,
  output logic tx_point,
  output logic rx_valid,
  output logic rx_bit,
  // Interrupt request pass-through
  input wire logic event_req,
  output logic irq_req,
  // Mode indication
  output logic [3:0] mode,
  // Bus pins
  input wire logic bus_receive_in,
  output logic bus_transmit_out
);

  // ***************************************************
  // Functions
  // ***************************************************
  function automatic logic [4:0] seg1_last(input logic [3:0] s1, input logic [2:0] ext);
    seg1_last = 5'(5'd1 + {1'b0, s1} + {2'b0, ext});
  endfunction : seg1_last

  function automatic logic [4:0] bit_last(input logic [4:0] s1l, input logic [2:0] s2);
    bit_last = 5'(s1l + {2'b0, s2} + 5'd1);
  endfunction : bit_last

  function automatic logic [2:0] min3(input logic [4:0] a, input logic [2:0] b);
    min3 = (a < {2'b0, b}) ? a[2:0] : b;
  endfunction : min3

  // ***************************************************
  // Registers
  // ***************************************************
  logic init_req_ff;
  logic sleep_req_ff;
  logic stop_in_wait_ff;
  logic module_enable_ff;
  logic init_ack_ff;
  logic sleep_ack_ff;
  cbt_pkg::cbt_timing_s tim_ff;
  cbt_pkg::cbt_mode_e mode_ff;
  cbt_pkg::cbt_mode_e nxt_mode;
  logic [7:0] rd_data_ff;
  logic [5:0] presc_cnt_ff;
  logic [4:0] tq_cnt_ff;
  logic [2:0] ext_ff;
  logic rx_prev_ff;
  logic edge_pend_ff;
  logic [1:0] rx_hist_ff;
  logic rx_bit_ff;
  logic rx_valid_ff;
  logic tx_point_ff;
  logic tx_ff;
  logic irq_ff;

  logic wr_hit_ctl;
  logic wr_hit_bt0;
  logic wr_hit_bt1;
  logic running;
  logic tq_en;
  logic [4:0] s1l;
  logic [4:0] blast;
  logic [2:0] jw;
  logic bit_end;
  logic samp_pt;
  logic resync;
  logic [4:0] seg2_rem;
  logic shorten_now;
  logic skip_end;
  logic lengthen;
  logic [2:0] ext_new;
  logic maj;
  logic pd_exit;

  assign wr_hit_ctl = bus_req.wr && (bus_req.addr == cbt_pkg::ADDR_CONTROL);
  assign wr_hit_bt0 = bus_req.wr && (bus_req.addr == cbt_pkg::ADDR_BUS_TIMING_0);
  assign wr_hit_bt1 = bus_req.wr && (bus_req.addr == cbt_pkg::ADDR_BUS_TIMING_1);

  // ***************************************************
  // Mode control
  // ***************************************************
  always_comb begin
    if (!module_enable_ff) begin
      nxt_mode = cbt_pkg::MD_DISABLED;
    end else if (cpu_mode == cbt_pkg::CPU_STOP) begin
      nxt_mode = cbt_pkg::MD_PWRDN;
    end else if ((cpu_mode == cbt_pkg::CPU_WAIT) && stop_in_wait_ff) begin
      nxt_mode = cbt_pkg::MD_PWRDN;
    end else if (mode_ff == cbt_pkg::MD_PWRDN) begin
      nxt_mode = cbt_pkg::MD_NORMAL;
    end else if (sleep_req_ff && sleep_ack_ff) begin
      nxt_mode = cbt_pkg::MD_SLEEP;
    end else begin
      nxt_mode = cbt_pkg::MD_NORMAL;
    end
  end

  assign pd_exit = (mode_ff == cbt_pkg::MD_PWRDN) && (nxt_mode != cbt_pkg::MD_PWRDN);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_ff <= cbt_pkg::MD_DISABLED;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Control register with restart clearing the sleep request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_req_ff <= cbt_pkg::RST_CONTROL[cbt_pkg::CTL_INIT_REQ];
      sleep_req_ff <= cbt_pkg::RST_CONTROL[cbt_pkg::CTL_SLEEP_REQ];
      stop_in_wait_ff <= cbt_pkg::RST_CONTROL[cbt_pkg::CTL_STOP_IN_WAIT];
      module_enable_ff <= cbt_pkg::RST_CONTROL[cbt_pkg::CTL_MODULE_ENABLE];
    end else if (wr_hit_ctl) begin
      init_req_ff <= bus_req.wdata[cbt_pkg::CTL_INIT_REQ];
      sleep_req_ff <= bus_req.wdata[cbt_pkg::CTL_SLEEP_REQ] && !pd_exit;
      stop_in_wait_ff <= bus_req.wdata[cbt_pkg::CTL_STOP_IN_WAIT];
      module_enable_ff <= bus_req.wdata[cbt_pkg::CTL_MODULE_ENABLE];
    end else if (pd_exit) begin
      sleep_req_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_ack_ff <= 1'b0;
    end else if (!module_enable_ff) begin
      init_ack_ff <= init_req_ff;
    end else begin
      init_ack_ff <= init_req_ff;
    end
  end

  // sleep acknowledge at idle bit boundary
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_ack_ff <= 1'b0;
    end else if (!sleep_req_ff || pd_exit) begin
      sleep_ack_ff <= 1'b0;
    end else if (!running || (bit_end && !tx_active && bus_receive_in)) begin
      sleep_ack_ff <= 1'b1;
    end
  end

  // ***************************************************
  // Bus timing registers
  // ***************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tim_ff.jump <= cbt_pkg::RST_BUS_TIMING_0[cbt_pkg::BT0_JUMP_MSB:cbt_pkg::BT0_JUMP_LSB];
      tim_ff.presc <= cbt_pkg::RST_BUS_TIMING_0[cbt_pkg::BT0_PRESC_MSB:cbt_pkg::BT0_PRESC_LSB];
    end else if (wr_hit_bt0 && init_ack_ff) begin
      tim_ff.jump <= bus_req.wdata[cbt_pkg::BT0_JUMP_MSB:cbt_pkg::BT0_JUMP_LSB];
      tim_ff.presc <= bus_req.wdata[cbt_pkg::BT0_PRESC_MSB:cbt_pkg::BT0_PRESC_LSB];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tim_ff.samp3 <= cbt_pkg::RST_BUS_TIMING_1[cbt_pkg::BT1_SAMP3];
      tim_ff.seg2 <= cbt_pkg::RST_BUS_TIMING_1[cbt_pkg::BT1_SEG2_MSB:cbt_pkg::BT1_SEG2_LSB];
      tim_ff.seg1 <= cbt_pkg::RST_BUS_TIMING_1[cbt_pkg::BT1_SEG1_MSB:cbt_pkg::BT1_SEG1_LSB];
    end else if (wr_hit_bt1 && init_ack_ff) begin
      tim_ff.samp3 <= bus_req.wdata[cbt_pkg::BT1_SAMP3];
      tim_ff.seg2 <= bus_req.wdata[cbt_pkg::BT1_SEG2_MSB:cbt_pkg::BT1_SEG2_LSB];
      tim_ff.seg1 <= bus_req.wdata[cbt_pkg::BT1_SEG1_MSB:cbt_pkg::BT1_SEG1_LSB];
    end
  end

  // ***************************************************
  // Register read
  // ***************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_ff <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        cbt_pkg::ADDR_CONTROL: begin
          rd_data_ff <= {4'h0, module_enable_ff, stop_in_wait_ff, sleep_req_ff, init_req_ff};
        end
        cbt_pkg::ADDR_STATUS: begin
          rd_data_ff <= {tx_ff, bus_receive_in, mode_ff, sleep_ack_ff, init_ack_ff};
        end
        cbt_pkg::ADDR_BUS_TIMING_0: begin
          rd_data_ff <= {tim_ff.jump, tim_ff.presc};
        end
        cbt_pkg::ADDR_BUS_TIMING_1: begin
          rd_data_ff <= {tim_ff.samp3, tim_ff.seg2, tim_ff.seg1};
        end
        default: begin
          rd_data_ff <= 8'h00;
        end
      endcase
    end else begin
      rd_data_ff <= 8'h00;
    end
  end

  // ***************************************************
  // Quantum prescaler
  // ***************************************************
  // runs in normal mode outside initialization, any processor mode
  assign running = (mode_ff == cbt_pkg::MD_NORMAL) && !init_ack_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_cnt_ff <= 6'h00;
    end else if (!running || tq_en) begin
      presc_cnt_ff <= 6'h00;
    end else begin
      presc_cnt_ff <= 6'(presc_cnt_ff + 6'h01);
    end
  end

  assign tq_en = running && (presc_cnt_ff == tim_ff.presc);

  // ***************************************************
  // Bit segment counter
  // ***************************************************
  // segment one span
  assign s1l = seg1_last(tim_ff.seg1, ext_ff);
  assign blast = bit_last(s1l, tim_ff.seg2);
  assign jw = {1'b0, tim_ff.jump} + 3'h1;
  assign seg2_rem = 5'(blast + 5'd1 - tq_cnt_ff);
  // Edge outside sync segment resynchronises
  assign resync = tq_en && edge_pend_ff && (tq_cnt_ff != 5'h00);
  assign lengthen = resync && (tq_cnt_ff <= s1l);
  assign ext_new = min3(tq_cnt_ff, jw);
  assign shorten_now = resync && (tq_cnt_ff > s1l) && (seg2_rem <= {2'b0, jw});
  // shortened phase two ends in this quantum
  assign skip_end = resync && (tq_cnt_ff > s1l) && (seg2_rem == 5'({2'b0, jw} + 5'd1));
  assign bit_end = tq_en && ((tq_cnt_ff == blast) || shorten_now || skip_end);
  // sample at end of segment one, later if it grows now
  assign samp_pt = tq_en && (tq_cnt_ff == s1l) && !(lengthen && (ext_new > ext_ff));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tq_cnt_ff <= 5'h00;
    end else if (!running) begin
      tq_cnt_ff <= 5'h00;
    end else if (shorten_now) begin
      tq_cnt_ff <= 5'h01;
    end else if (bit_end) begin
      tq_cnt_ff <= 5'h00;
    end else if (resync && (tq_cnt_ff > s1l)) begin
      tq_cnt_ff <= 5'(tq_cnt_ff + {2'b0, jw} + 5'd1);
    end else if (tq_en) begin
      tq_cnt_ff <= 5'(tq_cnt_ff + 5'd1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_ff <= 3'h0;
    end else if (!running || bit_end) begin
      ext_ff <= 3'h0;
    end else if (lengthen && (ext_new > ext_ff)) begin
      // Never shrink the stretch, so the sample point cannot be passed
      ext_ff <= ext_new;
    end
  end

  // Falling edge detect on receive pin
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_prev_ff <= cbt_pkg::LVL_RECESSIVE;
      edge_pend_ff <= 1'b0;
    end else begin
      rx_prev_ff <= bus_receive_in;
      if (!running || tq_en) begin
        edge_pend_ff <= running && rx_prev_ff && !bus_receive_in;
      end else if (rx_prev_ff && !bus_receive_in) begin
        edge_pend_ff <= 1'b1;
      end
    end
  end

  // ***************************************************
  // Receive sampling
  // ***************************************************
  assign maj = (rx_hist_ff[0] & rx_hist_ff[1]) | (rx_hist_ff[0] & bus_receive_in) |
               (rx_hist_ff[1] & bus_receive_in);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_hist_ff <= 2'h3;
      rx_bit_ff <= cbt_pkg::LVL_RECESSIVE;
      rx_valid_ff <= 1'b0;
    end else begin
      rx_valid_ff <= samp_pt;
      if (tq_en) begin
        rx_hist_ff <= {rx_hist_ff[0], bus_receive_in};
      end
      if (samp_pt) begin
        rx_bit_ff <= tim_ff.samp3 ? maj : bus_receive_in;
      end
    end
  end

  // ***************************************************
  // Transmit
  // ***************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_ff <= cbt_pkg::LVL_RECESSIVE;
      tx_point_ff <= 1'b0;
    end else if (!running) begin
      tx_ff <= cbt_pkg::LVL_RECESSIVE;
      tx_point_ff <= 1'b0;
    end else begin
      tx_point_ff <= bit_end;
      if (bit_end) begin
        tx_ff <= (tx_active && !tx_bit) ? cbt_pkg::LVL_DOMINANT : cbt_pkg::LVL_RECESSIVE;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= event_req && (mode_ff == cbt_pkg::MD_NORMAL);
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign rd_data = rd_data_ff;
  assign tx_point = tx_point_ff;
  assign rx_valid = rx_valid_ff;
  assign rx_bit = rx_bit_ff;
  assign irq_req = irq_ff;
  assign mode = mode_ff;
  assign bus_transmit_out = tx_ff;

endmodule : cbt_core

// [rtl/cbt_pkg.sv]
// Constants, types and register map of the bus bit-timing and mode block
// Summary of operation
// - Transmit output low means dominant, high means recessive.
// - Segment two field bits 6..4; value n gives n+1 quanta; zero invalid.
// - Segment one field bits 3..0; value n gives n+1 quanta; 0..2 invalid.
// - Bit lasts quantum time times one plus segment one plus segment two.
// - Quantum clock is controller clock divided by programmable prescaler.
// - Each bit opens with a one-quantum sync segment where edges expected.
// - Segment one spans propagation and first phase, 4 to 16 quanta.
// - Segment two is second phase segment, 2 to 8 quanta.
// - New transmit bit value goes onto bus at transmit point.
// - Bus sampled between segments; with three samples, this is the third.
// - Jump width programmable 1 to 4 quanta for resynchronization.
// - In run, sleep bits select normal or sleep; sleep only low-power state.
// - In wait with stop-in-wait set enter power-down, else follow sleep bits.
// - Leaving power-down entered from wait restarts into normal mode.
// - In wait and normal mode, bus operation and interrupt requests continue.
// - Processor stop forces power-down regardless of sleep and stop-in-wait.
// - Enable clear means disabled always; setting it enters normal mode.
// - Normal mode is inside or outside initialization; some writes restricted.
package cbt_pkg;

  // ***************************************************
  // Register map
  // ***************************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_BUS_TIMING_0 = 8'h02;
  localparam logic [7:0] ADDR_BUS_TIMING_1 = 8'h03;

  // Control register fields
  localparam int CTL_INIT_REQ = 0;
  localparam int CTL_SLEEP_REQ = 1;
  localparam int CTL_STOP_IN_WAIT = 2;
  localparam int CTL_MODULE_ENABLE = 3;

  // Status register fields
  localparam int STS_INIT_ACK = 0;
  localparam int STS_SLEEP_ACK = 1;
  localparam int STS_MODE_LSB = 2;
  localparam int STS_RX_LEVEL = 6;
  localparam int STS_TX_LEVEL = 7;

  // Bus timing 0 fields: jump width and prescaler
  localparam int BT0_JUMP_MSB = 7;
  localparam int BT0_JUMP_LSB = 6;
  localparam int BT0_PRESC_MSB = 5;
  localparam int BT0_PRESC_LSB = 0;

  // Bus timing 1 fields: three samples, segment two, segment one
  localparam int BT1_SAMP3 = 7;
  localparam int BT1_SEG2_MSB = 6;
  localparam int BT1_SEG2_LSB = 4;
  localparam int BT1_SEG1_MSB = 3;
  localparam int BT1_SEG1_LSB = 0;

  // ***************************************************
  // Reset values
  // ***************************************************
  localparam logic [7:0] RST_CONTROL = 8'h01;
  localparam logic [7:0] RST_BUS_TIMING_0 = 8'h00;
  localparam logic [7:0] RST_BUS_TIMING_1 = 8'h00;

  // ***************************************************
  // Levels and processor modes
  // ***************************************************
  localparam logic LVL_DOMINANT = 1'b0;
  localparam logic LVL_RECESSIVE = 1'b1;
  localparam logic [1:0] CPU_RUN = 2'h0;
  localparam logic [1:0] CPU_WAIT = 2'h1;
  localparam logic [1:0] CPU_STOP = 2'h2;

  typedef enum logic [3:0] {
    MD_DISABLED = 4'h1,
    MD_NORMAL = 4'h2,
    MD_SLEEP = 4'h4,
    MD_PWRDN = 4'h8
  } cbt_mode_e;

  typedef struct packed {
    logic samp3;
    logic [2:0] seg2;
    logic [3:0] seg1;
    logic [1:0] jump;
    logic [5:0] presc;
  } cbt_timing_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cbt_bus_req_s;

endpackage : cbt_pkg

// [tb/cbt_core_monitor.sv]
// Concurrent checks on the ports of the bit-timing and mode block
`timescale 1ns/1ns
module cbt_core_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire cbt_pkg::cbt_bus_req_s bus_req,
  input wire logic [7:0] rd_data,
  // Processor mode and events
  input wire logic [1:0] cpu_mode,
  input wire logic event_req,
  input wire logic irq_req,
  // Bit stream and pins
  input wire logic tx_point,
  input wire logic rx_valid,
  input wire logic [3:0] mode,
  input wire logic bus_transmit_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****************
  // Named steps
  // ****************
  sequence s_off2; (mode != cbt_pkg::MD_NORMAL)[*2]; endsequence
  sequence s_no_point4; (!tx_point)[*4]; endsequence
  sequence s_no_sample4; (!rx_valid)[*4]; endsequence
  sequence s_stat_rd; bus_req.rd && bus_req.addr == cbt_pkg::ADDR_STATUS; endsequence
  a_idle_recessive: assert property (s_off2 |-> bus_transmit_out)
    else $error("transmit not recessive outside normal mode");
  a_fall_at_point: assert property ($fell(bus_transmit_out) |-> tx_point)
    else $error("dominant level placed outside transmit point");
  a_point_spacing: assert property (tx_point |=> s_no_point4)
    else $error("transmit points too close");
  a_sample_late: assert property (tx_point |-> s_no_sample4)
    else $error("sample too early in bit");
  a_irq_follow: assert property ((mode == cbt_pkg::MD_NORMAL && event_req) ##1
    (mode == cbt_pkg::MD_NORMAL) |-> irq_req)
    else $error("event not passed in normal mode");
  a_irq_quiet: assert property (s_off2 |-> !irq_req)
    else $error("interrupt outside normal mode");
  a_stop_pwrdn: assert property ((cpu_mode == cbt_pkg::CPU_STOP) ##1 (cpu_mode ==
    cbt_pkg::CPU_STOP && mode != cbt_pkg::MD_DISABLED) |-> mode == cbt_pkg::MD_PWRDN)
    else $error("stop did not give power-down");
  a_pwrdn_exit: assert property (mode == cbt_pkg::MD_PWRDN && cpu_mode == cbt_pkg::CPU_RUN
    |=> mode inside {cbt_pkg::MD_NORMAL, cbt_pkg::MD_DISABLED})
    else $error("power-down not left into normal");
  a_mode_onehot: assert property ($onehot(mode))
    else $error("mode not one-hot");
  a_rd_idle: assert property (!bus_req.rd |=> rd_data == 8'h00)
    else $error("read data without read");
  a_status_mode: assert property (s_stat_rd |=> rd_data[5:2] == $past(mode))
    else $error("status mode field wrong");
endmodule : cbt_core_monitor

bind cbt_core cbt_core_monitor i_cbt_core_monitor (.clk(clk), .sys_rst(sys_rst),
  .bus_req(bus_req), .rd_data(rd_data), .cpu_mode(cpu_mode), .event_req(event_req),
  .irq_req(irq_req), .tx_point(tx_point), .rx_valid(rx_valid), .mode(mode),
  .bus_transmit_out(bus_transmit_out));

// [tb/cbt_transceiver.sv]
// Behavioural transceiver with a remote node that may pull the bus dominant
`timescale 1ns/1ns
module cbt_transceiver #(
  parameter int LOOP_DLY = 1
) (
  // Clock
  input wire logic clk,
  // Controller side
  input wire logic tx_pin,
  output logic rx_pin,
  // Remote node
  input wire logic remote_dom
);
  logic bus_line;
  logic [7:0] dly_ff = 8'hFF;
  logic [8:0] taps;
  assign bus_line = tx_pin & ~remote_dom;
  always_ff @(posedge clk) begin
    dly_ff <= {dly_ff[6:0], bus_line};
  end
  assign taps = {dly_ff, bus_line};
  assign rx_pin = taps[LOOP_DLY];
endmodule : cbt_transceiver

// [tb/cbt_core_test.sv]
// Self-checking bench for the bit-timing and mode block
`timescale 1ns/1ns
module cbt_core_test;
  logic clk, sys_rst, tx_active, tx_bit, tx_point, rx_valid, rx_bit;
  logic event_req, irq_req, bus_receive_in, bus_transmit_out, remote_dom;
  cbt_pkg::cbt_bus_req_s bus_req;
  logic [7:0] rd_data;
  logic [1:0] cpu_mode;
  logic [3:0] mode;
  logic rd_d, tx_bit_d, cur_bit;
  int num_errors = 0;
  int comparisons = 0;
  int cnt = 0;
  logic [15:0] rd_q[$];
  int gap_q[$];
  int samp_q[$];
  logic [31:0] mode_tab [10] = '{32'h00_09_09_3F, 32'h02_09_21_3F, 32'h00_09_09_3F,
    32'h01_0D_21_3F, 32'h00_0D_09_3F, 32'h00_0B_13_3F, 32'h01_0B_13_3F,
    32'h02_0B_21_3D, 32'h00_09_09_3F, 32'h00_01_05_3F};

  cbt_core i_cbt_core (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data(rd_data),
    .cpu_mode(cpu_mode), .tx_active(tx_active), .tx_bit(tx_bit), .tx_point(tx_point),
    .rx_valid(rx_valid), .rx_bit(rx_bit), .event_req(event_req), .irq_req(irq_req),
    .mode(mode), .bus_receive_in(bus_receive_in), .bus_transmit_out(bus_transmit_out));
  cbt_transceiver #(.LOOP_DLY(1)) i_cbt_transceiver (.clk(clk), .tx_pin(bus_transmit_out),
    .rx_pin(bus_receive_in), .remote_dom(remote_dom));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ****************
  // Tasks
  // ****************
  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error time=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte
  task chk_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error time=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task reg_wr(input logic [7:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
  endtask : reg_wr
  task reg_rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    rd_q.push_back({msk, exp});
    @(posedge clk);
  endtask : reg_rd
  task bus_idle(input int n);
    bus_req <= '0;
    repeat (n) @(posedge clk);
  endtask : bus_idle
  task wait_pt;
    int n;
    n = 0;
    @(negedge clk);
    while (tx_point !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n >= 400) num_errors++;
    @(posedge clk);
  endtask : wait_pt
  task run_cfg(input logic [5:0] p, input logic [3:0] s1, input logic [2:0] s2, input logic sm);
    reg_wr(cbt_pkg::ADDR_CONTROL, 8'h09);
    bus_idle(1);
    reg_wr(cbt_pkg::ADDR_BUS_TIMING_0, {2'b00, p});
    reg_wr(cbt_pkg::ADDR_BUS_TIMING_1, {sm, s2, s1});
    cur_bit = 1'b1;
    tx_active <= 1'b1;
    reg_wr(cbt_pkg::ADDR_CONTROL, 8'h08);
    bus_idle(1);
    wait_pt();
    repeat (3) begin
      gap_q.push_back((p + 1) * (s1 + s2 + 3));
      samp_q.push_back((p + 1) * (s1 + 2));
    end
    repeat (3) wait_pt();
    reg_wr(cbt_pkg::ADDR_BUS_TIMING_1, 8'h00);
    reg_rd(cbt_pkg::ADDR_BUS_TIMING_1, {sm, s2, s1}, 8'hFF);
    bus_idle(1);
  endtask : run_cfg
  task close_out;
    if (rd_q.size() + gap_q.size() + samp_q.size() > 0) num_errors++;
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  // ****************
  // Result watcher
  // ****************
  always @(posedge clk) rd_d <= bus_req.rd;
  always @(negedge clk) begin
    logic [15:0] e;
    cnt = cnt + 1;
    if (rd_d === 1'b1 && rd_q.size() > 0) begin
      e = rd_q.pop_front();
      chk_byte(rd_data & e[15:8], e[7:0]);
    end
    if (tx_point === 1'b1 && tx_active) begin
      chk_val({15'h0, bus_transmit_out}, {15'h0, tx_bit_d});
      cur_bit = tx_bit_d;
      if (gap_q.size() > 0) chk_val(16'(cnt), 16'(gap_q.pop_front()));
      cnt = 0;
    end
    if (rx_valid === 1'b1 && tx_active) begin
      chk_val({15'h0, rx_bit}, {15'h0, cur_bit & ~remote_dom});
      if (samp_q.size() > 0) chk_val(16'(cnt), 16'(samp_q.pop_front()));
    end
    tx_bit_d = tx_bit;
  end
  initial begin
    #(40 * 30000);
    num_errors++;
    close_out();
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    sys_rst = 1'b1;
    bus_req = '0;
    cpu_mode = 2'h0;
    tx_active = 1'b0;
    tx_bit = 1'b1;
    event_req = 1'b0;
    remote_dom = 1'b0;
    void'($urandom(61781));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    reg_rd(cbt_pkg::ADDR_CONTROL, cbt_pkg::RST_CONTROL, 8'hFF);
    reg_rd(cbt_pkg::ADDR_BUS_TIMING_0, cbt_pkg::RST_BUS_TIMING_0, 8'hFF);
    reg_rd(cbt_pkg::ADDR_BUS_TIMING_1, cbt_pkg::RST_BUS_TIMING_1, 8'hFF);
    reg_rd(cbt_pkg::ADDR_STATUS, 8'h05, 8'h3F);
    reg_wr(8'h07, 8'hFF);
    reg_rd(8'h07, 8'h00, 8'hFF);
    reg_wr(cbt_pkg::ADDR_BUS_TIMING_1, 8'hF7);
    reg_wr(cbt_pkg::ADDR_BUS_TIMING_0, 8'hC5);
    reg_rd(cbt_pkg::ADDR_BUS_TIMING_1, 8'hF7, 8'hFF);
    reg_rd(cbt_pkg::ADDR_BUS_TIMING_0, 8'hC5, 8'hFF);
    bus_idle(1);
    run_cfg(6'd0, 4'd4, 3'd1, 1'b0);
    run_cfg(6'd3, 4'd15, 3'd7, 1'b0);
    run_cfg(6'd1, 4'd5, 3'd2, 1'b0);
    run_cfg(6'd0, 4'd4, 3'd1, 1'b1);
    repeat (12) begin
      wait_pt();
      tx_bit <= 1'($urandom);
      remote_dom <= ($urandom % 4) == 0;
    end
    wait_pt();
    tx_bit <= 1'b1;
    remote_dom <= 1'b0;
    reg_wr(cbt_pkg::ADDR_CONTROL, 8'h09);
    tx_active <= 1'b0;
    cpu_mode <= 2'h1;
    event_req <= 1'b1;
    bus_idle(2);
    @(negedge clk);
    chk_val({15'h0, irq_req}, 16'h0001);
    @(posedge clk);
    cpu_mode <= 2'h2;
    bus_idle(3);
    @(negedge clk);
    chk_val({15'h0, irq_req}, 16'h0000);
    @(posedge clk);
    event_req <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      cpu_mode <= mode_tab[i][25:24];
      reg_wr(cbt_pkg::ADDR_CONTROL, mode_tab[i][23:16]);
      bus_idle(3);
      reg_rd(cbt_pkg::ADDR_STATUS, mode_tab[i][15:8], mode_tab[i][7:0]);
    end
    bus_idle(3);
    close_out();
  end
endmodule : cbt_core_test
